// ===== hdl/pfm_map.vh
/*
   Constants for the five-pad function multiplexer: select codes per pad,
   low-power pad modes and reset values. Assumes inclusion by pfm_pad_mux.v.
*/
`ifndef PFM_MAP_VH
`define PFM_MAP_VH

`define PFM_SEL_W           4
`define PFM_SEL_RST         4'h0
`define PFM_SEL_GPIO        4'h0

`define PFM_P10_I2C_CLK     4'h1
`define PFM_P10_PWM_SIX     4'h3
`define PFM_P10_SD_CLK      4'h6
`define PFM_P10_UART2_TX    4'h7
`define PFM_P10_CAP_ONE     4'hC

`define PFM_P11_I2C_DATA    4'h1
`define PFM_P11_PWM_SEVEN   4'h3
`define PFM_P11_PIX_CLK     4'h4
`define PFM_P11_SD_CMD      4'h6
`define PFM_P11_UART2_RX    4'h7
`define PFM_P11_CAP_TWO     4'hC
`define PFM_P11_AUD_FSYNC   4'hD

`define PFM_P12_AUD_BCLK    4'h3
`define PFM_P12_CAM_VSYNC   4'h4
`define PFM_P12_I2C_CLK     4'h5
`define PFM_P12_SECOND_UART_TRANSMIT    4'h7
`define PFM_P12_CAP_THREE   4'hC

`define PFM_P13_CAM_HSYNC   4'h4
`define PFM_P13_I2C_DATA    4'h5
`define PFM_P13_SECOND_UART_RECEIVE    4'h7
`define PFM_P13_CAP_FOUR    4'hC

`define PFM_P14_CAM_DATA    4'h4
`define PFM_P14_I2C_CLK     4'h5
`define PFM_P14_SPI_CLK     4'h7
`define PFM_P14_CAP_FIVE    4'hC

`define PFM_LPM_HIZ         2'h0
`define PFM_LPM_PULL_UP     2'h1
`define PFM_LPM_PULL_DN     2'h2
`define PFM_LPM_DRIVE       2'h3

`define PFM_LPF_NONE        2'h0
`define PFM_LPF_HIGH        2'h1
`define PFM_LPF_LOW         2'h2

`endif

// ===== hdl/pfm_pad_cell.v
/*
   One pad cell: registered pad drive, enable and pulls, chosen from the
   active function, the low-power state and the reset pin; plus a
   two-stage synchroniser for the pad's input level.
   Assumes all control inputs are already on CLK_SYS.
*/
`timescale 1ns/10ps
`include "pfm_map.vh"

module pfm_pad_cell (
   input  wire       clk,
   input  wire       srst,
   input  wire       rst_pin_low,
   input  wire       deep_sleep,
   input  wire       hibernate,
   input  wire       fn_out,
   input  wire       fn_oe,
   input  wire       fn_od,
   input  wire [1:0] lp_fix,
   input  wire [1:0] lp_mode,
   input  wire       lp_level,
   input  wire       pad_in,
   output reg        pad_out_ff,
   output reg        pad_oe_ff,
   output reg        pull_up_ff,
   output reg        pull_dn_ff,
   output reg        in_sync_ff
);

reg in_meta_ff;
reg nxt_out;
reg nxt_oe;
reg nxt_pu;
reg nxt_pd;

////////////////////////////////////////////////////////////////////////////////
// Pad state selection

always @* begin
   nxt_out = 1'b0;
   nxt_oe  = 1'b0;
   nxt_pu  = 1'b0;
   nxt_pd  = 1'b0;
   if (rst_pin_low) begin
      nxt_oe = 1'b0;
   end else if (hibernate || (deep_sleep && lp_fix == `PFM_LPF_NONE)) begin
      // Sleep setting applies in hibernate whatever function is selected, in deep sleep only where the function sets no fixed level
      case (lp_mode)
         `PFM_LPM_PULL_UP: nxt_pu = 1'b1;
         `PFM_LPM_PULL_DN: nxt_pd = 1'b1;
         `PFM_LPM_DRIVE: begin
            nxt_oe  = 1'b1;
            nxt_out = lp_level;
         end
         default: nxt_oe = 1'b0;
      endcase
   end else if (deep_sleep) begin
      nxt_oe  = 1'b1;
      nxt_out = (lp_fix == `PFM_LPF_HIGH);
   end else if (fn_od) begin
      nxt_oe  = fn_oe;
      nxt_out = 1'b0;
   end else begin
      nxt_oe  = fn_oe;
      nxt_out = fn_out;
   end
end

always @(posedge clk) begin
   if (srst) begin
      pad_out_ff <= 1'b0;
      pad_oe_ff  <= 1'b0;
      pull_up_ff <= 1'b0;
      pull_dn_ff <= 1'b0;
      in_meta_ff <= 1'b0;
      in_sync_ff <= 1'b0;
   end else begin
      pad_out_ff <= nxt_out;
      pad_oe_ff  <= nxt_oe;
      pull_up_ff <= nxt_pu;
      pull_dn_ff <= nxt_pd;
      in_meta_ff <= pad_in;
      in_sync_ff <= in_meta_ff;
   end
end

endmodule // pfm_pad_cell

// ===== hdl/pfm_pad_mux.v
/*
   Function multiplexer for the five pads general I/O lines ten to fourteen
   (bit 0 = line ten ... bit 4 = line fourteen). Routes peripheral signals
   to pads by per-pad select code and fixes pad state in deep sleep,
   hibernate and while the external reset pin is low.
   Assumes peripherals, select strobes and sleep levels are on CLK_SYS;
   pad inputs and the reset pin are asynchronous.
*/
`timescale 1ns/10ps
`include "pfm_map.vh"

module pfm_pad_mux #(
   parameter NPAD = 5
) (
   input  wire                 CLK_SYS,
   input  wire                 SRST,
   input  wire                 ACTIVE_LOW_RESET_INPUT_N,
   input  wire                 LOW_POWER_DEEP_SLEEP,
   input  wire                 HIBERNATE,
   input  wire [NPAD-1:0]      SEL_LOAD,
   input  wire [3:0]           SEL_LINE_TEN,
   input  wire [3:0]           SEL_LINE_ELEVEN,
   input  wire [3:0]           SEL_LINE_TWELVE,
   input  wire [3:0]           SEL_LINE_THIRTEEN,
   input  wire [3:0]           SEL_LINE_FOURTEEN,
   input  wire [2*NPAD-1:0]    SLEEP_MODE,
   input  wire [NPAD-1:0]      SLEEP_LEVEL,
   input  wire [NPAD-1:0]      GENERAL_IO_OUT,
   input  wire [NPAD-1:0]      GENERAL_IO_OE,
   input  wire                 I2C_CLOCK_PULL_LOW,
   input  wire                 I2C_DATA_PULL_LOW,
   input  wire                 TIMER_PWM_OUT_SIX,
   input  wire                 TIMER_PWM_OUT_SEVEN,
   input  wire                 SD_CARD_CLOCK,
   input  wire                 SD_CARD_COMMAND_PULL_LOW,
   input  wire                 SECOND_UART_TRANSMIT,
   input  wire                 FIRST_UART_TRANSMIT,
   input  wire                 CAMERA_PIXEL_CLOCK_OUT,
   input  wire                 AUDIO_FRAME_SYNC_OUT,
   input  wire                 AUDIO_BIT_CLOCK_OUT,
   input  wire                 SPI_CLOCK_OUT,
   input  wire                 SPI_CLOCK_OE,
   input  wire [NPAD-1:0]      PAD_IN,
   output wire [NPAD-1:0]      PAD_OUT,
   output wire [NPAD-1:0]      PAD_OE,
   output wire [NPAD-1:0]      PAD_PULL_UP,
   output wire [NPAD-1:0]      PAD_PULL_DOWN,
   output reg  [NPAD-1:0]      GENERAL_IO_IN,
   output reg                  I2C_CLOCK_IN,
   output reg                  I2C_DATA_IN,
   output reg                  SD_CARD_COMMAND_IN,
   output reg                  SECOND_UART_RECEIVE,
   output reg                  FIRST_UART_RECEIVE,
   output reg                  CAMERA_VERTICAL_SYNC,
   output reg                  CAMERA_HORIZONTAL_SYNC,
   output reg                  CAMERA_DATA_BIT,
   output reg                  SPI_CLOCK_IN,
   output reg  [NPAD-1:0]      TIMER_CAPTURE_IN
);

reg  [3:0]        sel_ten_ff;
reg  [3:0]        sel_eleven_ff;
reg  [3:0]        sel_twelve_ff;
reg  [3:0]        sel_thirteen_ff;
reg  [3:0]        sel_fourteen_ff;
reg               rst_meta_ff;
reg               rst_sync_ff;
reg  [NPAD-1:0]   fn_out;
reg  [NPAD-1:0]   fn_oe;
reg  [NPAD-1:0]   fn_od;
reg  [2*NPAD-1:0] lp_fix;
reg               nxt_i2c_clk;
reg               nxt_i2c_dat;
reg               nxt_sd_cmd;
reg               nxt_uart2_rx;
reg               nxt_second_uart_receive;
reg               nxt_vsync;
reg               nxt_hsync;
reg               nxt_cam_dat;
reg               nxt_spi_clk;
reg  [NPAD-1:0]   nxt_cap;
wire [NPAD-1:0]   in_sync;

////////////////////////////////////////////////////////////////////////////////
// Select codes and reset pin synchroniser

always @(posedge CLK_SYS) begin
   if (SRST) begin
      sel_ten_ff      <= `PFM_SEL_RST;
      sel_eleven_ff   <= `PFM_SEL_RST;
      sel_twelve_ff   <= `PFM_SEL_RST;
      sel_thirteen_ff <= `PFM_SEL_RST;
      sel_fourteen_ff <= `PFM_SEL_RST;
      rst_meta_ff     <= 1'b0;
      rst_sync_ff     <= 1'b0;
   end else begin
      if (SEL_LOAD[0]) sel_ten_ff      <= SEL_LINE_TEN;
      if (SEL_LOAD[1]) sel_eleven_ff   <= SEL_LINE_ELEVEN;
      if (SEL_LOAD[2]) sel_twelve_ff   <= SEL_LINE_TWELVE;
      if (SEL_LOAD[3]) sel_thirteen_ff <= SEL_LINE_THIRTEEN;
      if (SEL_LOAD[4]) sel_fourteen_ff <= SEL_LINE_FOURTEEN;
      rst_meta_ff <= ACTIVE_LOW_RESET_INPUT_N;
      rst_sync_ff <= rst_meta_ff;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Function routing; shared inputs (I2C clock and data) are wired-AND

always @* begin
   fn_out       = {NPAD{1'b0}};
   fn_oe        = {NPAD{1'b0}};
   fn_od        = {NPAD{1'b0}};
   lp_fix       = {2*NPAD{1'b0}};
   nxt_i2c_clk  = 1'b1;
   nxt_i2c_dat  = 1'b1;
   nxt_sd_cmd   = 1'b1;
   nxt_uart2_rx = 1'b1;
   nxt_second_uart_receive = 1'b1;
   nxt_vsync    = 1'b0;
   nxt_hsync    = 1'b0;
   nxt_cam_dat  = 1'b0;
   nxt_spi_clk  = 1'b0;
   nxt_cap      = {NPAD{1'b0}};

   case (sel_ten_ff)
      `PFM_SEL_GPIO: begin
         fn_out[0] = GENERAL_IO_OUT[0];
         fn_oe[0]  = GENERAL_IO_OE[0];
      end
      `PFM_P10_I2C_CLK: begin
         fn_od[0]    = 1'b1;
         fn_oe[0]    = I2C_CLOCK_PULL_LOW;
         nxt_i2c_clk = nxt_i2c_clk & in_sync[0];
      end
      `PFM_P10_PWM_SIX: begin
         fn_out[0] = TIMER_PWM_OUT_SIX;
         fn_oe[0]  = 1'b1;
      end
      `PFM_P10_SD_CLK: begin
         fn_out[0]  = SD_CARD_CLOCK;
         fn_oe[0]   = 1'b1;
         lp_fix[1:0] = `PFM_LPF_LOW;
      end
      `PFM_P10_UART2_TX: begin
         fn_out[0]  = SECOND_UART_TRANSMIT;
         fn_oe[0]   = 1'b1;
         lp_fix[1:0] = `PFM_LPF_HIGH;
      end
      `PFM_P10_CAP_ONE: nxt_cap[0] = in_sync[0];
      default: fn_oe[0] = 1'b0;
   endcase

   case (sel_eleven_ff)
      `PFM_SEL_GPIO: begin
         fn_out[1] = GENERAL_IO_OUT[1];
         fn_oe[1]  = GENERAL_IO_OE[1];
      end
      `PFM_P11_I2C_DATA: begin
         fn_od[1]    = 1'b1;
         fn_oe[1]    = I2C_DATA_PULL_LOW;
         nxt_i2c_dat = nxt_i2c_dat & in_sync[1];
      end
      `PFM_P11_PWM_SEVEN: begin
         fn_out[1] = TIMER_PWM_OUT_SEVEN;
         fn_oe[1]  = 1'b1;
      end
      `PFM_P11_PIX_CLK: begin
         fn_out[1]  = CAMERA_PIXEL_CLOCK_OUT;
         fn_oe[1]   = 1'b1;
         lp_fix[3:2] = `PFM_LPF_LOW;
      end
      `PFM_P11_SD_CMD: begin
         fn_od[1]   = 1'b1;
         fn_oe[1]   = SD_CARD_COMMAND_PULL_LOW;
         nxt_sd_cmd = in_sync[1];
      end
      `PFM_P11_UART2_RX: nxt_uart2_rx = in_sync[1];
      `PFM_P11_CAP_TWO:  nxt_cap[1]   = in_sync[1];
      `PFM_P11_AUD_FSYNC: begin
         fn_out[1] = AUDIO_FRAME_SYNC_OUT;
         fn_oe[1]  = 1'b1;
      end
      default: fn_oe[1] = 1'b0;
   endcase

   case (sel_twelve_ff)
      `PFM_SEL_GPIO: begin
         fn_out[2] = GENERAL_IO_OUT[2];
         fn_oe[2]  = GENERAL_IO_OE[2];
      end
      `PFM_P12_AUD_BCLK: begin
         fn_out[2] = AUDIO_BIT_CLOCK_OUT;
         fn_oe[2]  = 1'b1;
      end
      `PFM_P12_CAM_VSYNC: nxt_vsync = in_sync[2];
      `PFM_P12_I2C_CLK: begin
         fn_od[2]    = 1'b1;
         fn_oe[2]    = I2C_CLOCK_PULL_LOW;
         nxt_i2c_clk = nxt_i2c_clk & in_sync[2];
      end
      `PFM_P12_SECOND_UART_TRANSMIT: begin
         fn_out[2]  = FIRST_UART_TRANSMIT;
         fn_oe[2]   = 1'b1;
         lp_fix[5:4] = `PFM_LPF_HIGH;
      end
      `PFM_P12_CAP_THREE: nxt_cap[2] = in_sync[2];
      default: fn_oe[2] = 1'b0;
   endcase

   case (sel_thirteen_ff)
      `PFM_SEL_GPIO: begin
         fn_out[3] = GENERAL_IO_OUT[3];
         fn_oe[3]  = GENERAL_IO_OE[3];
      end
      `PFM_P13_CAM_HSYNC: nxt_hsync = in_sync[3];
      `PFM_P13_I2C_DATA: begin
         fn_od[3]    = 1'b1;
         fn_oe[3]    = I2C_DATA_PULL_LOW;
         nxt_i2c_dat = nxt_i2c_dat & in_sync[3];
      end
      `PFM_P13_SECOND_UART_RECEIVE: nxt_second_uart_receive = in_sync[3];
      `PFM_P13_CAP_FOUR: nxt_cap[3]   = in_sync[3];
      default: fn_oe[3] = 1'b0;
   endcase

   case (sel_fourteen_ff)
      `PFM_SEL_GPIO: begin
         fn_out[4] = GENERAL_IO_OUT[4];
         fn_oe[4]  = GENERAL_IO_OE[4];
      end
      `PFM_P14_CAM_DATA: nxt_cam_dat = in_sync[4];
      `PFM_P14_I2C_CLK: begin
         fn_od[4]    = 1'b1;
         fn_oe[4]    = I2C_CLOCK_PULL_LOW;
         nxt_i2c_clk = nxt_i2c_clk & in_sync[4];
      end
      `PFM_P14_SPI_CLK: begin
         fn_out[4]   = SPI_CLOCK_OUT;
         fn_oe[4]    = SPI_CLOCK_OE;
         nxt_spi_clk = in_sync[4];
      end
      `PFM_P14_CAP_FIVE: nxt_cap[4] = in_sync[4];
      default: fn_oe[4] = 1'b0;
   endcase
end

always @(posedge CLK_SYS) begin
   if (SRST) begin
      GENERAL_IO_IN          <= {NPAD{1'b0}};
      I2C_CLOCK_IN           <= 1'b1;
      I2C_DATA_IN            <= 1'b1;
      SD_CARD_COMMAND_IN     <= 1'b1;
      SECOND_UART_RECEIVE    <= 1'b1;
      FIRST_UART_RECEIVE     <= 1'b1;
      CAMERA_VERTICAL_SYNC   <= 1'b0;
      CAMERA_HORIZONTAL_SYNC <= 1'b0;
      CAMERA_DATA_BIT        <= 1'b0;
      SPI_CLOCK_IN           <= 1'b0;
      TIMER_CAPTURE_IN       <= {NPAD{1'b0}};
   end else begin
      GENERAL_IO_IN          <= in_sync;
      I2C_CLOCK_IN           <= nxt_i2c_clk;
      I2C_DATA_IN            <= nxt_i2c_dat;
      SD_CARD_COMMAND_IN     <= nxt_sd_cmd;
      SECOND_UART_RECEIVE    <= nxt_uart2_rx;
      FIRST_UART_RECEIVE     <= nxt_second_uart_receive;
      CAMERA_VERTICAL_SYNC   <= nxt_vsync;
      CAMERA_HORIZONTAL_SYNC <= nxt_hsync;
      CAMERA_DATA_BIT        <= nxt_cam_dat;
      SPI_CLOCK_IN           <= nxt_spi_clk;
      TIMER_CAPTURE_IN       <= nxt_cap;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Pad cells

genvar gi;
generate
   for (gi = 0; gi < NPAD; gi = gi + 1) begin : g_pad
      pfm_pad_cell u_cell (
         .clk         (CLK_SYS),
         .srst        (SRST),
         .rst_pin_low (~rst_sync_ff),
         .deep_sleep  (LOW_POWER_DEEP_SLEEP),
         .hibernate   (HIBERNATE),
         .fn_out      (fn_out[gi]),
         .fn_oe       (fn_oe[gi]),
         .fn_od       (fn_od[gi]),
         .lp_fix      (lp_fix[2*gi+1:2*gi]),
         .lp_mode     (SLEEP_MODE[2*gi+1:2*gi]),
         .lp_level    (SLEEP_LEVEL[gi]),
         .pad_in      (PAD_IN[gi]),
         .pad_out_ff  (PAD_OUT[gi]),
         .pad_oe_ff   (PAD_OE[gi]),
         .pull_up_ff  (PAD_PULL_UP[gi]),
         .pull_dn_ff  (PAD_PULL_DOWN[gi]),
         .in_sync_ff  (in_sync[gi])
      );
   end
endgenerate

endmodule // pfm_pad_mux

// ===== tb/pfm_pad_mux_monitor.sv
/* Pad-state assertions for pfm_pad_mux.
   Assumes a bind to pfm_pad_mux and one clock. */
`timescale 1ns/10ps
module pfm_pad_mux_monitor #(
   parameter NPAD = 5
) (
   input wire              CLK_SYS,
   input wire              SRST,
   input wire              ACTIVE_LOW_RESET_INPUT_N,
   input wire              LOW_POWER_DEEP_SLEEP,
   input wire              HIBERNATE,
   input wire [NPAD-1:0]   SEL_LOAD,
   input wire [3:0]        SEL_LINE_TEN,
   input wire [3:0]        SEL_LINE_ELEVEN,
   input wire [3:0]        SEL_LINE_TWELVE,
   input wire [3:0]        SEL_LINE_THIRTEEN,
   input wire [2*NPAD-1:0] SLEEP_MODE,
   input wire [NPAD-1:0]   SLEEP_LEVEL,
   input wire              I2C_DATA_PULL_LOW,
   input wire [NPAD-1:0]   PAD_IN,
   input wire [NPAD-1:0]   PAD_OUT,
   input wire [NPAD-1:0]   PAD_OE,
   input wire [NPAD-1:0]   PAD_PULL_UP,
   input wire [NPAD-1:0]   PAD_PULL_DOWN,
   input wire              FIRST_UART_RECEIVE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   reg  [1:0]      pin_cnt_ff;
   reg  [3:0]      sel_ff [0:3];
   wire            ok = pin_cnt_ff == 2'h3;
   wire            act = ok && !LOW_POWER_DEEP_SLEEP && !HIBERNATE;
   wire            ds = ok && LOW_POWER_DEEP_SLEEP && !HIBERNATE;
   wire [NPAD-1:0] pulls = PAD_PULL_UP | PAD_PULL_DOWN;
   ////////////////////////////////////////////////////////////////////////////////
   // Pin high long enough for the pad stage to see it; shadow select codes
   always @(posedge CLK_SYS) begin
      if (SRST || !ACTIVE_LOW_RESET_INPUT_N)
         pin_cnt_ff <= 2'h0;
      else if (!ok)
         pin_cnt_ff <= pin_cnt_ff + 2'h1;
      if (SRST || SEL_LOAD[0])
         sel_ff[0] <= SRST ? 4'h0 : SEL_LINE_TEN;
      if (SRST || SEL_LOAD[1])
         sel_ff[1] <= SRST ? 4'h0 : SEL_LINE_ELEVEN;
      if (SRST || SEL_LOAD[2])
         sel_ff[2] <= SRST ? 4'h0 : SEL_LINE_TWELVE;
      if (SRST || SEL_LOAD[3])
         sel_ff[3] <= SRST ? 4'h0 : SEL_LINE_THIRTEEN;
   end
   ////////////////////////////////////////////////////////////////////////////////
   pin_reset_hiz_a: assert property (
      !ACTIVE_LOW_RESET_INPUT_N [*3] |=> PAD_OE == '0 && pulls == '0)
      else $error("pad active while reset pin low");
   hib_hiz_a: assert property (
      HIBERNATE && SLEEP_MODE == '0 |=> PAD_OE == '0 && pulls == '0)
      else $error("pad not high impedance in hibernate");
   sleep_drive_a: assert property (
      ok && HIBERNATE && SLEEP_MODE == '1 |=> PAD_OE == '1 && PAD_OUT == $past(SLEEP_LEVEL))
      else $error("sleep drive level not applied");
   ds_uart_high_a: assert property (
      ds && sel_ff[2] == 4'h7 |=> PAD_OUT[2] && PAD_OE[2])
      else $error("uart transmit pad not high in deep sleep");
   ds_clk_low_a: assert property (
      ds && sel_ff[0] == 4'h6 |=> !PAD_OUT[0] && PAD_OE[0])
      else $error("card clock pad not low in deep sleep");
   open_drain_a: assert property (
      act && sel_ff[1] == 4'h1 |=> !PAD_OUT[1] && PAD_OE[1] == $past(I2C_DATA_PULL_LOW))
      else $error("open drain pad driven high");
   ds_unused_hiz_a: assert property (
      ds && sel_ff[3] == 4'h0 && SLEEP_MODE == '0 |=> !PAD_OE[3] && !pulls[3])
      else $error("unused pad not high impedance in deep sleep");
   uart_rx_route_a: assert property (
      (act && sel_ff[3] == 4'h7) [*4] |-> FIRST_UART_RECEIVE == $past(PAD_IN[3], 3))
      else $error("uart receive not taken from pad");
   ds_uart_c: cover property (ds && sel_ff[2] == 4'h7);
   hib_drive_c: cover property (ok && HIBERNATE && SLEEP_MODE == '1);
   pin_low_c: cover property (!ACTIVE_LOW_RESET_INPUT_N [*3]);
endmodule // pfm_pad_mux_monitor

bind pfm_pad_mux pfm_pad_mux_monitor #(.NPAD(NPAD)) u_mon (
   .CLK_SYS(CLK_SYS), .SRST(SRST), .ACTIVE_LOW_RESET_INPUT_N(ACTIVE_LOW_RESET_INPUT_N),
   .LOW_POWER_DEEP_SLEEP(LOW_POWER_DEEP_SLEEP), .HIBERNATE(HIBERNATE), .SEL_LOAD(SEL_LOAD),
   .SEL_LINE_TEN(SEL_LINE_TEN), .SEL_LINE_ELEVEN(SEL_LINE_ELEVEN),
   .SEL_LINE_TWELVE(SEL_LINE_TWELVE), .SEL_LINE_THIRTEEN(SEL_LINE_THIRTEEN),
   .SLEEP_MODE(SLEEP_MODE), .SLEEP_LEVEL(SLEEP_LEVEL), .I2C_DATA_PULL_LOW(I2C_DATA_PULL_LOW),
   .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .PAD_PULL_UP(PAD_PULL_UP),
   .PAD_PULL_DOWN(PAD_PULL_DOWN), .FIRST_UART_RECEIVE(FIRST_UART_RECEIVE));

// ===== tb/pfm_periph_model.sv
/* Far side: peripheral outputs and the board wire of each pad.
   Assumes the bench gives a board level for each pad. */
`timescale 1ns/10ps
module pfm_periph_model (
   input  wire       clk,
   input  wire [4:0] pad_out,
   input  wire [4:0] pad_oe,
   input  wire [4:0] pull_up,
   input  wire [4:0] pull_dn,
   input  wire [4:0] board_lvl,
   output wire [4:0] pad_wire,
   output wire [7:0] periph_out
);
   reg [7:0] cnt_ff = 8'h00;
   // Peripheral outputs step just after each clock edge
   always @(posedge clk)
      cnt_ff <= #1 cnt_ff + 8'h01;
   assign periph_out = cnt_ff ^ {cnt_ff[3:0], cnt_ff[7:4]};
   // Driven pad, else its pull, else the board level
   assign pad_wire = pad_oe & pad_out | ~pad_oe & (pull_up | ~pull_dn & board_lvl);
endmodule // pfm_periph_model

// ===== tb/test_pfm_pad_mux.sv
/* Self-checking bench for pfm_pad_mux against a cycle model of pad states.
   Assumes pfm_periph_model and the bound monitor are compiled first. */
`timescale 1ns/10ps
module test_pfm_pad_mux;
   logic        clk = 1'b0, srst = 1'b1, pin = 1'b1, ds = 1'b0, hib = 1'b0;
   logic        p1 = 1'b0, p2 = 1'b0, armed = 1'b0;
   logic [4:0]  load = 5'h00, gio_out = 5'h00, gio_oe = 5'h00, lvl = 5'h00, ext = 5'h00;
   logic [4:0]  pl = 5'h00;
   logic [9:0]  smode = 10'h000;
   logic [3:0]  sel_in [0:4] = '{default: 4'h0};
   logic [31:0] r = 32'h0000000E;
   logic [4:0]  eo [0:4];
   int          sel_m [0:4] = '{default: 0};
   int          n_fail = 0, n_checks = 0, i, p;
   wire  [7:0]  per;
   wire  [4:0]  pad_in, pad_out, pad_oe, pu, pd;
   wire  [18:0] rx;

   always #2 clk = ~clk;

   pfm_pad_mux DUT (
      .CLK_SYS(clk), .SRST(srst), .ACTIVE_LOW_RESET_INPUT_N(pin),
      .LOW_POWER_DEEP_SLEEP(ds), .HIBERNATE(hib), .SEL_LOAD(load),
      .SEL_LINE_TEN(sel_in[0]), .SEL_LINE_ELEVEN(sel_in[1]), .SEL_LINE_TWELVE(sel_in[2]),
      .SEL_LINE_THIRTEEN(sel_in[3]), .SEL_LINE_FOURTEEN(sel_in[4]), .SLEEP_MODE(smode),
      .SLEEP_LEVEL(lvl), .GENERAL_IO_OUT(gio_out), .GENERAL_IO_OE(gio_oe),
      .I2C_CLOCK_PULL_LOW(pl[0]), .I2C_DATA_PULL_LOW(pl[1]),
      .SD_CARD_COMMAND_PULL_LOW(pl[2]), .SPI_CLOCK_OUT(pl[3]), .SPI_CLOCK_OE(pl[4]),
      .TIMER_PWM_OUT_SIX(per[0]), .TIMER_PWM_OUT_SEVEN(per[1]), .SD_CARD_CLOCK(per[2]),
      .SECOND_UART_TRANSMIT(per[3]), .FIRST_UART_TRANSMIT(per[4]),
      .CAMERA_PIXEL_CLOCK_OUT(per[5]), .AUDIO_FRAME_SYNC_OUT(per[6]),
      .AUDIO_BIT_CLOCK_OUT(per[7]), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
      .PAD_PULL_UP(pu), .PAD_PULL_DOWN(pd), .GENERAL_IO_IN(rx[18:14]),
      .I2C_CLOCK_IN(rx[10]), .I2C_DATA_IN(rx[11]), .SD_CARD_COMMAND_IN(rx[12]),
      .SECOND_UART_RECEIVE(rx[0]),
      .CAMERA_VERTICAL_SYNC(rx[1]), .FIRST_UART_RECEIVE(rx[2]),
      .CAMERA_HORIZONTAL_SYNC(rx[3]), .CAMERA_DATA_BIT(rx[4]), .SPI_CLOCK_IN(rx[13]),
      .TIMER_CAPTURE_IN(rx[9:5]));

   pfm_periph_model u_far (
      .clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pu), .pull_dn(pd),
      .board_lvl(ext), .pad_wire(pad_in), .periph_out(per));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h00400007 : 32'h00000000);
   endfunction

   // Next pad state {pulls checked, oe, out, pull up, pull down}
   function automatic logic [4:0] expect_pad(int k);
      logic [1:0] m;
      int         c;
      m = smode[2*k +: 2];
      c = sel_m[k];
      if (srst || !p2)
         return 5'h10;
      if (ds && !hib && (k == 0 || k == 2) && c == 7)
         return 5'h0C;
      if (ds && !hib && (k == 0 && c == 6 || k == 1 && c == 4))
         return 5'h08;
      if (ds || hib)
         return {1'b1, m == 2'h3, m == 2'h3 && lvl[k], m == 2'h1, m == 2'h2};
      if (c == 0)
         return {1'b0, gio_oe[k], gio_out[k], 2'h0};
      case (k * 16 + c)
         1, 37, 69: return {1'b0, pl[0], 3'h0};
         17, 53:    return {1'b0, pl[1], 3'h0};
         22:        return {1'b0, pl[2], 3'h0};
         3:         return {2'h1, per[0], 2'h0};
         6:         return {2'h1, per[2], 2'h0};
         7:         return {2'h1, per[3], 2'h0};
         19:        return {2'h1, per[1], 2'h0};
         20:        return {2'h1, per[5], 2'h0};
         29:        return {2'h1, per[6], 2'h0};
         35:        return {2'h1, per[7], 2'h0};
         39:        return {2'h1, per[4], 2'h0};
         71:        return {1'b0, pl[4], pl[3], 2'h0};
         default:   return 5'h00;
      endcase
   endfunction

   task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
      end
   endtask

   // Reference model takes pre-edge inputs, like the design's registers
   always @(posedge clk) begin
      for (int k = 0; k < 5; k++) begin
         eo[k] = expect_pad(k);
         eo[k][2] = eo[k][2] & eo[k][3];
      end
      for (int k = 0; k < 5; k++)
         if (srst || load[k])
            sel_m[k] = srst ? 0 : sel_in[k];
      p2 = srst ? 1'b0 : p1;
      p1 = srst ? 1'b0 : pin;
      armed = 1'b1;
   end

   always @(negedge clk)
      if (armed)
         for (int k = 0; k < 5; k++) begin
            chk({pad_oe[k], pad_oe[k] & pad_out[k]}, eo[k][3:2]);
            if (eo[k][4])
               chk({pu[k], pd[k]}, eo[k][1:0]);
         end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic step();
      @(posedge clk);
      #1;
   endtask

   task automatic ld(int k, logic [3:0] c);
      sel_in[k] = c;
      load = 5'h01 << k;
      step();
      load = 5'h00;
   endtask

   // Input function: board level reaches the peripheral after three edges
   task automatic rx_case(int k, logic [3:0] c, int idx);
      ld(k, c);
      for (int v = 0; v < 2; v++) begin
         ext[k] = v[0];
         repeat (4) step();
         chk({1'b0, rx[idx]}, {1'b0, v[0]});
      end
   endtask

   task automatic tally_and_finish();
      if (n_fail == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #20000;
      n_fail++;
      $display("[FAIL] %0t run timed out", $time);
      tally_and_finish();
   end

   initial begin
      repeat (5) step();
      srst = 1'b0;
      repeat (4) step();
      for (i = 0; i < 400; i++) begin
         r = lfsr(r);
         load = r[4:0] & r[9:5];
         for (p = 0; p < 5; p++)
            sel_in[p] = r[10 + 4 * p +: 4];
         r = lfsr(r);
         {gio_oe, gio_out, lvl, ext} = r[19:0];
         smode = r[29:20];
         r = lfsr(r);
         pl = r[4:0];
         ds = r[5];
         hib = r[6] & r[7];
         pin = ~(r[8] & r[9] & r[10]);
         step();
      end
      {ds, hib, pin, smode} = {3'h1, 10'h000};
      sel_in = '{4'h6, 4'h1, 4'h7, 4'h0, 4'h0};
      load = 5'h1F;
      step();
      load = 5'h00;
      repeat (4) step();
      ds = 1'b1;
      repeat (4) step();
      hib = 1'b1;
      repeat (3) step();
      smode = 10'h3FF;
      repeat (3) step();
      pin = 1'b0;
      repeat (4) step();
      {ds, hib, pin} = 3'h1;
      repeat (4) step();
      rx_case(1, 4'h7, 0);
      rx_case(2, 4'h4, 1);
      rx_case(3, 4'h7, 2);
      rx_case(3, 4'h4, 3);
      rx_case(4, 4'h4, 4);
      for (p = 0; p < 5; p++)
         rx_case(p, 4'hC, 5 + p);
      // Open-drain, SPI clock and general inputs: nothing may drive the pad meanwhile
      {pl, gio_oe} = 10'h000;
      rx_case(0, 4'h1, 10);
      rx_case(2, 4'h5, 10);
      rx_case(4, 4'h5, 10);
      ext[0] = 1'b0;
      repeat (4) step();
      chk({1'b0, rx[10]}, 2'h0);
      rx_case(1, 4'h1, 11);
      rx_case(3, 4'h5, 11);
      rx_case(1, 4'h6, 12);
      rx_case(4, 4'h7, 13);
      for (p = 0; p < 5; p++)
         rx_case(p, 4'h0, 14 + p);
      srst = 1'b1;
      repeat (5) step();
      srst = 1'b0;
      repeat (4) step();
      tally_and_finish();
   end
endmodule // test_pfm_pad_mux
